// File: rtl/rx_cfg_pkg.sv
// Shared constants for the receive decoder and demodulator configuration bank
package rx_cfg_pkg;
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   // Printed register offsets kept as indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] DEC_THR_IDX = 8'h18;
   localparam logic [ADDR_W-1:0] DEMOD_IDX = 8'h19;
   localparam logic [ADDR_W-1:0] DEC_THR_ADDR = 8'h60;
   localparam logic [ADDR_W-1:0] DEMOD_ADDR = 8'h64;
   // Values after reset
   localparam logic [REG_W-1:0] DEC_THR_RST = 8'h84;
   localparam logic [REG_W-1:0] DEMOD_RST = 8'h4D;
   // Writable bits of the threshold register; bit 3 stays zero
   localparam logic [REG_W-1:0] DEC_THR_MASK = 8'hF7;
   // Field positions
   localparam int MIN_LVL_LSB = 4;
   localparam int MIN_LVL_W = 4;
   localparam int COLL_LSB = 0;
   localparam int COLL_W = 3;
   localparam int CH_USE_LSB = 6;
   localparam int CH_USE_W = 2;
   localparam int FIX_SEL_BIT = 5;
   // Width of the half-bit amplitude and channel amplitude samples
   localparam int AMP_W = 8;
   // Collision threshold is in eighths of the stronger half-bit
   localparam int COLL_SCALE_SH = 3;
   // Channel-use encodings
   typedef enum logic [1:0] {
      CH_STRONGEST = 2'b00,
      CH_FROZEN = 2'b01,
      CH_RSVD_A = 2'b10,
      CH_RSVD_B = 2'b11
   } ch_use_e;
endpackage

// File: rtl/channel_pick.sv
// I/Q channel choice for the demodulator, per the channel-use settings
`timescale 1ns/1ns
module channel_pick
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [rx_cfg_pkg::AMP_W-1:0] iAmplitude,
   input wire logic [rx_cfg_pkg::AMP_W-1:0] qAmplitude,
   input wire logic [rx_cfg_pkg::CH_USE_W-1:0] iqChannelUse,
   input wire logic fixedChannelSelect,
   input wire logic exchangeActive,
   output logic useQChannel
);
   import rx_cfg_pkg::*;
   logic useQ_q;
   logic useQ_d;
   logic activeSeen_q;
   logic strongerIsQ;
   logic exchangeStart;

   // Ties go to I so the choice never flickers on equal amplitudes
   assign strongerIsQ = qAmplitude > iAmplitude;
   assign exchangeStart = exchangeActive && !activeSeen_q;

   // Fixed channel overrides every automatic mode
   always_comb begin
      useQ_d = useQ_q;
      if (fixedChannelSelect) begin
         useQ_d = iqChannelUse[0];
      end else begin
         unique case (ch_use_e'(iqChannelUse))
            CH_STRONGEST: useQ_d = strongerIsQ;
            CH_FROZEN: useQ_d = (exchangeActive && !exchangeStart) ? useQ_q : strongerIsQ;
            CH_RSVD_A: useQ_d = useQ_q; // Reserved codes hold the last choice
            CH_RSVD_B: useQ_d = useQ_q;
         endcase
      end
   end

   // Choice and exchange edge tracking
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         useQ_q <= 1'b0;
         activeSeen_q <= 1'b0;
      end else begin
         useQ_q <= useQ_d;
         activeSeen_q <= exchangeActive;
      end
   end

   assign useQChannel = useQ_q;
endmodule

// File: rtl/receiver_decoder_config_regs.sv
// Decoder threshold and demodulator settings registers with the logic they steer
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module receiver_decoder_config_regs
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rx_cfg_pkg::ADDR_W-1:0] paddr,
   input wire logic [rx_cfg_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [rx_cfg_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sampleValid,
   input wire logic [rx_cfg_pkg::MIN_LVL_W-1:0] signalStrength,
   input wire logic halfBitValid,
   input wire logic [rx_cfg_pkg::AMP_W-1:0] firstHalfAmp,
   input wire logic [rx_cfg_pkg::AMP_W-1:0] secondHalfAmp,
   input wire logic [rx_cfg_pkg::AMP_W-1:0] iAmplitude,
   input wire logic [rx_cfg_pkg::AMP_W-1:0] qAmplitude,
   input wire logic exchangeActive,
   output logic sampleAccepted,
   output logic bitCollision,
   output logic useQChannel
);
   import rx_cfg_pkg::*;
   // Register state
   logic [REG_W-1:0] decoderThreshold_q;
   logic [REG_W-1:0] decoderThreshold_d;
   logic [REG_W-1:0] demodulatorSettings_q;
   logic [REG_W-1:0] demodulatorSettings_d;
   logic [DATA_W-1:0] prdata_q;
   logic [DATA_W-1:0] prdata_d;
   logic sampleAccepted_q;
   logic bitCollision_q;

   // Bus decode
   logic setupPhase;
   logic accessPhase;
   logic hitThreshold;
   logic hitDemod;
   logic hitAny;
   logic wrThreshold;
   logic wrDemod;
   logic lane0;

   // Field views
   logic [MIN_LVL_W-1:0] minSignalLevel;
   logic [COLL_W-1:0] collisionThreshold;
   logic [CH_USE_W-1:0] iqChannelUse;
   logic fixedChannelSelect;

   // Decoder arithmetic
   logic [AMP_W-1:0] weakHalf;
   logic [AMP_W-1:0] strongHalf;
   logic [AMP_W+COLL_SCALE_SH-1:0] weakScaled;
   logic [AMP_W+COLL_SCALE_SH-1:0] strongScaled;
   logic levelOk;
   logic collisionHit;

   // Larger of two amplitudes, used to pick the stronger half-bit; pickMin gives the weaker
   function automatic logic [AMP_W-1:0] pickMax(input logic [AMP_W-1:0] a,
                                                input logic [AMP_W-1:0] b);
      pickMax = (a > b) ? a : b;
   endfunction

   function automatic logic [AMP_W-1:0] pickMin(input logic [AMP_W-1:0] a,
                                                input logic [AMP_W-1:0] b);
      pickMin = (a > b) ? b : a;
   endfunction

   // APB phase and address decode; only word-aligned byte addresses hit
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign hitThreshold = (paddr == DEC_THR_ADDR);
   assign hitDemod = (paddr == DEMOD_ADDR);
   assign hitAny = hitThreshold || hitDemod;
   assign lane0 = pstrb[0];
   assign wrThreshold = accessPhase && pwrite && hitThreshold && lane0;
   assign wrDemod = accessPhase && pwrite && hitDemod && lane0;

   // Zero wait states; read data was latched in the setup cycle
   assign pready = accessPhase;
   assign pslverr = accessPhase && !hitAny;
   assign prdata = prdata_q;

   // Next register values; threshold bit 3 forced low so it can never steer anything
   assign decoderThreshold_d = wrThreshold ? (pwdata[REG_W-1:0] & DEC_THR_MASK)
                                           : decoderThreshold_q;
   assign demodulatorSettings_d = wrDemod ? pwdata[REG_W-1:0] : demodulatorSettings_q;

   // Read data capture; unmapped reads return zero together with the error
   always_comb begin
      prdata_d = prdata_q;
      if (setupPhase && !pwrite) begin
         prdata_d = '0;
         if (hitThreshold) begin
            prdata_d[REG_W-1:0] = decoderThreshold_q;
         end else if (hitDemod) begin
            prdata_d[REG_W-1:0] = demodulatorSettings_q;
         end
      end
   end

   // Register file
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         decoderThreshold_q <= DEC_THR_RST;
         demodulatorSettings_q <= DEMOD_RST;
         prdata_q <= '0;
      end else begin
         decoderThreshold_q <= decoderThreshold_d;
         demodulatorSettings_q <= demodulatorSettings_d;
         prdata_q <= prdata_d;
      end
   end

   // Field extraction
   assign minSignalLevel = decoderThreshold_q[MIN_LVL_LSB +: MIN_LVL_W];
   assign collisionThreshold = decoderThreshold_q[COLL_LSB +: COLL_W];
   assign iqChannelUse = demodulatorSettings_q[CH_USE_LSB +: CH_USE_W];
   assign fixedChannelSelect = demodulatorSettings_q[FIX_SEL_BIT];

   // Level gate: samples below the minimum are not accepted; collision is judged regardless of level
   assign levelOk = sampleValid && (signalStrength >= minSignalLevel);

   // Collision: weak * 8 reaches strong * threshold, both in eighths
   assign weakHalf = pickMin(firstHalfAmp, secondHalfAmp);
   assign strongHalf = pickMax(firstHalfAmp, secondHalfAmp);
   assign weakScaled = {weakHalf, {COLL_SCALE_SH{1'b0}}};
   assign strongScaled = {{COLL_SCALE_SH{1'b0}}, strongHalf}
                         * {{AMP_W{1'b0}}, collisionThreshold}; // Widened first, cannot wrap
   assign collisionHit = halfBitValid && (weakScaled >= strongScaled);

   // Decoder verdicts are registered, one cycle after their inputs
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sampleAccepted_q <= 1'b0;
         bitCollision_q <= 1'b0;
      end else begin
         sampleAccepted_q <= levelOk;
         bitCollision_q <= collisionHit;
      end
   end

   assign sampleAccepted = sampleAccepted_q;
   assign bitCollision = bitCollision_q;

   // Channel choice lives in its own module to keep the mode logic together
   channel_pick pick (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .iAmplitude(iAmplitude),
      .qAmplitude(qAmplitude),
      .iqChannelUse(iqChannelUse),
      .fixedChannelSelect(fixedChannelSelect),
      .exchangeActive(exchangeActive),
      .useQChannel(useQChannel)
   );

   // Register checks: values after reset, writes, and no change on any other cycle
   AST_RESET_VALUES: assert property (@(posedge ref_clk)
      $rose(resetn) |-> (decoderThreshold_q == 8'h84 && demodulatorSettings_q == 8'h4D
         && prdata == 32'h0000_0000 && !sampleAccepted && !bitCollision && !useQChannel))
      else $error("state after reset wrong");

   AST_THR_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
      wrThreshold |=> decoderThreshold_q == ($past(pwdata[REG_W-1:0]) & 8'hF7))
      else $error("threshold register did not take the write");

   AST_DEMOD_WRITE: assert property (@(posedge ref_clk) disable iff (!resetn)
      wrDemod |=> demodulatorSettings_q == $past(pwdata[REG_W-1:0]))
      else $error("demodulator register did not take the write");

   AST_THR_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
      !wrThreshold |=> $stable(decoderThreshold_q))
      else $error("threshold register changed without a write");

   AST_DEMOD_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
      !wrDemod |=> $stable(demodulatorSettings_q))
      else $error("demodulator register changed without a write");

   AST_THR_BIT3: assert property (@(posedge ref_clk) disable iff (!resetn)
      !decoderThreshold_q[3])
      else $error("reserved threshold bit stored as one");

   AST_THR_RSVD: assert property (@(posedge ref_clk) disable iff (!resetn)
      (setupPhase && !pwrite && hitThreshold) |=> prdata_q[3] == 1'b0)
      else $error("reserved threshold bit read back as one");

   AST_STRB_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
      (accessPhase && pwrite && !pstrb[0]) |=> ($stable(decoderThreshold_q)
         && $stable(demodulatorSettings_q)))
      else $error("write with low lane strobe changed a register");

   // Bus checks: zero wait states, error only for unmapped addresses
   AST_READY: assert property (@(posedge ref_clk) disable iff (!resetn)
      accessPhase |-> pready)
      else $error("access cycle without ready");

   AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (!resetn)
      !accessPhase |-> (!pready && !pslverr))
      else $error("ready or error outside an access cycle");

   AST_MAPPED_OK: assert property (@(posedge ref_clk) disable iff (!resetn)
      (accessPhase && hitAny) |-> !pslverr)
      else $error("mapped access refused");

   AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!resetn)
      (accessPhase && !hitAny) |-> (pslverr && pready))
      else $error("unmapped access not refused");

   // Read data: loaded at the setup edge, then held through the access cycle
   AST_RD_THR: assert property (@(posedge ref_clk) disable iff (!resetn)
      (setupPhase && !pwrite && hitThreshold) |=> prdata == {24'h0, $past(decoderThreshold_q)})
      else $error("threshold read data wrong");

   AST_RD_DEMOD: assert property (@(posedge ref_clk) disable iff (!resetn)
      (setupPhase && !pwrite && hitDemod) |=> prdata == {24'h0, $past(demodulatorSettings_q)})
      else $error("demodulator read data wrong");

   AST_RD_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!resetn)
      (setupPhase && !pwrite && !hitAny) |=> prdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   AST_RD_UPPER: assert property (@(posedge ref_clk) disable iff (!resetn)
      prdata[DATA_W-1:REG_W] == 24'h00_0000)
      else $error("upper read data bits not zero");

   AST_RD_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(setupPhase && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read setup");

   // Decoder checks: level gate and collision verdict, one cycle after the input
   AST_ACCEPT: assert property (@(posedge ref_clk) disable iff (!resetn)
      (sampleValid && signalStrength >= decoderThreshold_q[7:4]) |=> sampleAccepted)
      else $error("strong sample not accepted");

   AST_REJECT: assert property (@(posedge ref_clk) disable iff (!resetn)
      (sampleValid && signalStrength < decoderThreshold_q[7:4]) |=> !sampleAccepted)
      else $error("weak sample accepted");

   AST_NO_SAMPLE: assert property (@(posedge ref_clk) disable iff (!resetn)
      !sampleValid |=> !sampleAccepted)
      else $error("accept without a sample");

   AST_COLLISION: assert property (@(posedge ref_clk) disable iff (!resetn)
      halfBitValid |=> bitCollision ==
         ($past(weakHalf) * 8 >= $past(strongHalf) * $past(decoderThreshold_q[2:0])))
      else $error("collision verdict wrong");

   AST_NO_HALF_BIT: assert property (@(posedge ref_clk) disable iff (!resetn)
      !halfBitValid |=> !bitCollision)
      else $error("collision without a half-bit pair");

   AST_COLL_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
      (halfBitValid && decoderThreshold_q[2:0] == 3'h0) |=> bitCollision)
      else $error("zero collision threshold did not flag");

   // Channel checks: fixed bit first, then the automatic codes
   AST_FIXED_CH: assert property (@(posedge ref_clk) disable iff (!resetn)
      demodulatorSettings_q[5] |=> useQChannel == $past(demodulatorSettings_q[6]))
      else $error("fixed channel not honoured");

   AST_AUTO_CH: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!demodulatorSettings_q[5] && demodulatorSettings_q[7:6] == 2'b00)
         |=> useQChannel == $past(qAmplitude > iAmplitude))
      else $error("strongest channel not chosen");

   AST_FROZEN_IDLE: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!demodulatorSettings_q[5] && demodulatorSettings_q[7:6] == 2'b01 && !exchangeActive)
         |=> useQChannel == $past(qAmplitude > iAmplitude))
      else $error("channel not tracked between exchanges");

   AST_FROZEN_START: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!demodulatorSettings_q[5] && demodulatorSettings_q[7:6] == 2'b01
         && exchangeActive && !$past(exchangeActive)) |=> useQChannel == $past(qAmplitude > iAmplitude))
      else $error("channel not chosen at exchange start");

   AST_FROZEN_CH: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!demodulatorSettings_q[5] && demodulatorSettings_q[7:6] == 2'b01
         && exchangeActive && $past(exchangeActive)) |=> $stable(useQChannel))
      else $error("frozen channel changed during exchange");

   AST_RSVD_MODE: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!demodulatorSettings_q[5] && demodulatorSettings_q[7]) |=> $stable(useQChannel))
      else $error("reserved channel code changed the choice");

   // Main scenarios reached
   COV_THR_WRITE: cover property (@(posedge ref_clk) disable iff (!resetn) wrThreshold);
   COV_UNMAPPED: cover property (@(posedge ref_clk) disable iff (!resetn) accessPhase && !hitAny);
   COV_COLLISION: cover property (@(posedge ref_clk) disable iff (!resetn) bitCollision);
   COV_FROZEN: cover property (@(posedge ref_clk) disable iff (!resetn)
      (demodulatorSettings_q[7:6] == 2'b01 && exchangeActive) [*3]);
   COV_FIXED_Q: cover property (@(posedge ref_clk) disable iff (!resetn)
      demodulatorSettings_q[5] && useQChannel);
endmodule

// File: tb/receiver_decoder_config_regs_bench.sv
// Self-checking bench for the decoder threshold and demodulator settings registers
`timescale 1ns/1ns
module receiver_decoder_config_regs_bench;
   import rx_cfg_pkg::*;
   logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic sampleValid, halfBitValid, exchangeActive;
   logic sampleAccepted, bitCollision, useQChannel;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd, d;
   logic [3:0] pstrb, s;
   logic [MIN_LVL_W-1:0] signalStrength;
   logic [AMP_W-1:0] firstHalfAmp, secondHalfAmp, iAmplitude, qAmplitude, a, b;
   logic [7:0] thr;
   int mismatches = 0;
   int compares = 0;
   int seed = 10677;

   receiver_decoder_config_regs i_dut (.ref_clk, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sampleValid, .signalStrength,
      .halfBitValid, .firstHalfAmp, .secondHalfAmp, .iAmplitude, .qAmplitude,
      .exchangeActive, .sampleAccepted, .bitCollision, .useQChannel);

   // Free-running 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                      input logic [3:0] st);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      pstrb <= st;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Collision when weaker half times eight reaches stronger half times the threshold
   function automatic logic coll_exp(input logic [7:0] x, input logic [7:0] y,
                                     input logic [2:0] c);
      int w;
      int g;
      w = (x < y) ? x : y;
      g = (x < y) ? y : x;
      return (w * 8 >= g * c);
   endfunction

   // One decoder sample; outputs are registered, so look one edge later
   task automatic samp(input logic [3:0] st, input logic [7:0] x, input logic [7:0] y);
      @(posedge ref_clk);
      sampleValid <= 1'b1;
      halfBitValid <= 1'b1;
      signalStrength <= st;
      firstHalfAmp <= x;
      secondHalfAmp <= y;
      @(posedge ref_clk);
      sampleValid <= 1'b0;
      halfBitValid <= 1'b0;
      @(negedge ref_clk);
      check("sampleAccepted", 32'(sampleAccepted), 32'(st >= thr[7:4]));
      check("bitCollision", 32'(bitCollision), 32'(coll_exp(x, y, thr[2:0])));
   endtask

   // Channel inputs for one cycle, choice checked after the taking edge
   task automatic chan(input logic ex, input logic [7:0] i, input logic [7:0] q,
                       input logic expQ);
      @(posedge ref_clk);
      exchangeActive <= ex;
      iAmplitude <= i;
      qAmplitude <= q;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("useQChannel", 32'(useQChannel), 32'(expQ));
   endtask

   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, sampleValid, halfBitValid, exchangeActive} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      signalStrength = '0;
      {firstHalfAmp, secondHalfAmp, iAmplitude, qAmplitude} = '0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      apb(1'b0, DEC_THR_ADDR, '0, 4'hF);
      check("threshold reset", rd, 32'h0000_0084);
      apb(1'b0, DEMOD_ADDR, '0, 4'hF);
      check("demod reset", rd, 32'h0000_004D);
      $display("test reset done");
      // Random writes; bit 3 of the threshold must read back as zero
      repeat (6) begin
         d = $random(seed);
         apb(1'b1, DEC_THR_ADDR, d, 4'hF);
         apb(1'b0, DEC_THR_ADDR, '0, 4'hF);
         check("threshold rw", rd, {24'h0, d[7:0] & DEC_THR_MASK});
         check("threshold rw err", 32'(err), 32'h0);
         apb(1'b1, DEMOD_ADDR, ~d, 4'hF);
         apb(1'b0, DEMOD_ADDR, '0, 4'hF);
         check("demod rw", rd, {24'h0, ~d[7:0]});
      end
      // Strobe off is ignored without error, then the printed index used as a byte address is refused
      apb(1'b1, DEC_THR_ADDR, 32'h0000_0008, 4'hE);
      check("strobe off err", 32'(err), 32'h0);
      apb(1'b1, DEC_THR_IDX, 32'h0000_00FF, 4'hF);
      check("unmapped write err", 32'(err), 32'h1);
      apb(1'b0, DEC_THR_IDX, '0, 4'hF);
      check("unmapped read", {rd[31:1], err}, 32'h1);
      apb(1'b0, DEC_THR_ADDR, '0, 4'hF);
      check("threshold kept", rd, {24'h0, d[7:0] & DEC_THR_MASK});
      $display("test registers done");
      // Decoder levels, boundary strength included
      repeat (12) begin
         thr = 8'($random(seed)) & DEC_THR_MASK;
         apb(1'b1, DEC_THR_ADDR, {24'h0, thr}, 4'h1);
         a = 8'($random(seed));
         b = 8'($random(seed));
         samp(thr[7:4], a, b);
         s = 4'($random(seed));
         samp(s, a, a >> 1);
      end
      $display("test decoder done");
      // Fixed channel: low bit of channel use picks I or Q regardless of strength
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, DEMOD_ADDR, {24'h0, 2'(m), 1'b1, 5'h0D}, 4'h1);
         chan(1'b0, 8'h80, 8'h10, m[0]);
         chan(1'b0, 8'h10, 8'h80, m[0]);
      end
      apb(1'b1, DEMOD_ADDR, {24'h0, CH_STRONGEST, 1'b0, 5'h0D}, 4'h1);
      chan(1'b0, 8'h40, 8'h40, 1'b0);
      repeat (8) begin
         a = 8'($random(seed));
         b = 8'($random(seed));
         chan(1'b1, a, b, b > a);
      end
      // Frozen choice holds for the whole exchange
      apb(1'b1, DEMOD_ADDR, {24'h0, CH_FROZEN, 1'b0, 5'h0D}, 4'h1);
      chan(1'b0, 8'h10, 8'h20, 1'b1);
      chan(1'b1, 8'h10, 8'h20, 1'b1);
      chan(1'b1, 8'h30, 8'h20, 1'b1);
      chan(1'b0, 8'h30, 8'h20, 1'b0);
      // Reserved codes keep the last choice
      apb(1'b1, DEMOD_ADDR, {24'h0, CH_RSVD_A, 1'b0, 5'h0D}, 4'h1);
      chan(1'b0, 8'h10, 8'h20, 1'b0);
      apb(1'b1, DEMOD_ADDR, {24'h0, CH_RSVD_B, 1'b0, 5'h0D}, 4'h1);
      chan(1'b0, 8'h10, 8'h20, 1'b0);
      $display("test channel done");
      tally_and_finish();
   end

   // Whole run is a few hundred cycles; far longer means a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      tally_and_finish();
   end
endmodule
